// *** design/tpg_gen.sv ***
// Converter test pattern generator: replaces converter words with test words
// ahead of the output formatting stage, with its register file.
// Assumes conversion samples and register accesses come from core_clk logic.
`timescale 1ns/1ps
`include "tpg_regs.svh"
module tpg_gen
	import tpg_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic ddc_mode,
	input wire logic conv_valid,
	input wire logic [13:0] conv_a,
	input wire logic [13:0] conv_b,
	output logic conv_ready,
	output logic out_valid,
	input wire logic out_ready,
	output logic out_test,
	output logic [13:0] out_a,
	output logic [13:0] out_b
);
	// Advances a PN register by one sample; returns next state and output word
	// Fourteen bits per sample, first bit lands in bit 15, bits 1:0 stay zero
	function automatic logic [38:0] tpg_pn16(input logic [22:0] s, input int len, input int tap);
		logic [22:0] st;
		logic [15:0] w;
		logic fb;
		st = s;
		w = '0;
		fb = 1'b0;
		for (int k = 0; k < 14; k++) begin
			fb = st[0] ^ st[tap];
			w[15 - k] = st[0];
			st = {1'b0, st[22:1]};
			st[len - 1] = fb;
		end
		return {st, w};
	endfunction

	// Maps the control code to a pattern; unlisted codes mean off
	function automatic tpg_pat_type tpg_decode(input logic [3:0] code);
		tpg_pat_type p;
		p = TPG_PAT_OFF;
		case (code)
			`TPG_CODE_MID: p = TPG_PAT_MID;
			`TPG_CODE_POS: p = TPG_PAT_POS;
			`TPG_CODE_NEG: p = TPG_PAT_NEG;
			`TPG_CODE_CHECK: p = TPG_PAT_CHECK;
			`TPG_CODE_PN_LONG: p = TPG_PAT_PN_LONG;
			`TPG_CODE_PN_SHORT: p = TPG_PAT_PN_SHORT;
			`TPG_CODE_TOGGLE: p = TPG_PAT_TOGGLE;
			`TPG_CODE_USER: p = TPG_PAT_USER;
			`TPG_CODE_RAMP: p = TPG_PAT_RAMP;
			default: p = TPG_PAT_OFF;
		endcase
		return p;
	endfunction

	// Register file
	logic [7:0] ctrl_ff;
	logic [7:0] ddc_first_ff;
	logic [7:0] ddc_second_ff;
	logic [7:0] user_ff [8];
	logic [7:0] rdata_ff;

	// Pattern state
	logic [22:0] pn_long_ff;
	logic [22:0] pn_short_ff;
	logic [13:0] ramp_ff;
	logic phase_ff;
	logic [1:0] uidx_ff;
	logic udone_ff;

	// Fifo side
	logic fifo_ready;
	tpg_sample_type fifo_out;

	// Register decode
	wire wr_ctrl = clk_en & reg_wr & (reg_addr == `TPG_ADDR_CTRL);
	wire wr_ddc_first = clk_en & reg_wr & (reg_addr == `TPG_ADDR_DDC_FIRST);
	wire wr_ddc_second = clk_en & reg_wr & (reg_addr == `TPG_ADDR_DDC_SECOND);
	wire in_user = (reg_addr >= `TPG_ADDR_USER_FIRST) & (reg_addr <= `TPG_ADDR_USER_LAST);
	wire [11:0] user_off = reg_addr - `TPG_ADDR_USER_FIRST;
	wire [2:0] user_idx = user_off[2:0];
	wire wr_user = clk_en & reg_wr & in_user;
	wire [7:0] rd_mux = (reg_addr == `TPG_ADDR_CTRL) ? ctrl_ff :
		(reg_addr == `TPG_ADDR_DDC_FIRST) ? ddc_first_ff :
		(reg_addr == `TPG_ADDR_DDC_SECOND) ? ddc_second_ff :
		in_user ? user_ff[user_idx] : 8'h00;

	// Control fields
	wire [3:0] code = ctrl_ff[`TPG_CTRL_CODE_MSB:0];
	wire long_hold = ctrl_ff[`TPG_CTRL_LONG_RST_BIT];
	wire short_hold = ctrl_ff[`TPG_CTRL_SHORT_RST_BIT];
	wire single_mode = ctrl_ff[`TPG_CTRL_SINGLE_BIT];
	tpg_pat_type pat;
	assign pat = tpg_decode(code);

	// Downconverter test enable: both enable bits of either downconverter
	wire ddc_test_first = ddc_first_ff[`TPG_DDC_EN_LO_BIT] & ddc_first_ff[`TPG_DDC_EN_HI_BIT];
	wire ddc_test_second = ddc_second_ff[`TPG_DDC_EN_LO_BIT] & ddc_second_ff[`TPG_DDC_EN_HI_BIT];
	wire ddc_test = ddc_test_first | ddc_test_second;
	wire test_on = (pat != TPG_PAT_OFF) & (~ddc_mode | ddc_test);

	// PN words and next states
	wire [38:0] pn_long_step = tpg_pn16(pn_long_ff, `TPG_PN_LONG_LEN, `TPG_PN_LONG_TAP);
	wire [38:0] pn_short_step = tpg_pn16(pn_short_ff, `TPG_PN_SHORT_LEN, `TPG_PN_SHORT_TAP);
	wire [13:0] pn_long_word = pn_long_step[15:2];
	wire [13:0] pn_short_word = pn_short_step[15:2];
	wire [15:0] user_word = {user_ff[{uidx_ff, 1'b1}], user_ff[{uidx_ff, 1'b0}]};

	// Pattern word selection
	logic [13:0] pat_word;
	always_comb begin
		case (pat)
			TPG_PAT_MID: pat_word = `TPG_WORD_ZERO;
			TPG_PAT_POS: pat_word = `TPG_WORD_POS;
			TPG_PAT_NEG: pat_word = `TPG_WORD_NEG;
			TPG_PAT_CHECK: pat_word = phase_ff ? `TPG_WORD_CHK_B : `TPG_WORD_CHK_A;
			TPG_PAT_PN_LONG: pat_word = pn_long_word;
			TPG_PAT_PN_SHORT: pat_word = pn_short_word;
			TPG_PAT_TOGGLE: pat_word = phase_ff ? `TPG_WORD_ONES : `TPG_WORD_ZERO;
			TPG_PAT_USER: pat_word = udone_ff ? `TPG_WORD_ZERO : user_word[15:2];
			TPG_PAT_RAMP: pat_word = ramp_ff;
			default: pat_word = `TPG_WORD_ZERO;
		endcase
	end

	// Sample accepted: patterns move only on a real sample
	wire push = clk_en & conv_valid & fifo_ready;
	tpg_sample_type sample;
	assign sample.test = test_on;
	assign sample.lane_a = test_on ? pat_word : conv_a;
	assign sample.lane_b = test_on ? pat_word : conv_b;
	assign conv_ready = fifo_ready;

	// Register writes
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_ff <= `TPG_RST_CTRL;
			ddc_first_ff <= `TPG_RST_DDC;
			ddc_second_ff <= `TPG_RST_DDC;
			for (int i = 0; i < 8; i++) begin
				user_ff[i] <= `TPG_RST_USER;
			end
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= reg_wdata;
			end
			if (wr_ddc_first) begin
				ddc_first_ff <= reg_wdata;
			end
			if (wr_ddc_second) begin
				ddc_second_ff <= reg_wdata;
			end
			if (wr_user) begin
				user_ff[user_idx] <= reg_wdata;
			end
		end
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_ff <= 8'h00;
		end else if (clk_en & reg_rd) begin
			rdata_ff <= rd_mux;
		end
	end
	assign reg_rdata = rdata_ff;

	// PN generators: held at seed while their reset bit is set
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pn_long_ff <= `TPG_PN_LONG_SEED;
			pn_short_ff <= `TPG_PN_SHORT_SEED;
		end else if (clk_en) begin
			if (long_hold) begin
				pn_long_ff <= `TPG_PN_LONG_SEED;
			end else if (push & (pat == TPG_PAT_PN_LONG)) begin
				pn_long_ff <= pn_long_step[38:16];
			end
			if (short_hold) begin
				pn_short_ff <= `TPG_PN_SHORT_SEED;
			end else if (push & (pat == TPG_PAT_PN_SHORT)) begin
				pn_short_ff <= pn_short_step[38:16];
			end
		end
	end

	// Ramp, alternation and user index; a control write restarts them
	always_ff @(posedge core_clk) begin
		if (reset | wr_ctrl) begin
			ramp_ff <= 14'h0000;
			phase_ff <= 1'b0;
			uidx_ff <= 2'h0;
			udone_ff <= 1'b0;
		end else if (push) begin
			ramp_ff <= ramp_ff + 14'h0001;
			phase_ff <= ~phase_ff;
			uidx_ff <= uidx_ff + 2'h1;
			udone_ff <= udone_ff | (single_mode & (uidx_ff == 2'h3));
		end
	end

	tpg_fifo #(
		.W($bits(tpg_sample_type)),
		.DEPTH(8)
	) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.in_valid(conv_valid),
		.in_ready(fifo_ready),
		.in_data(sample),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(fifo_out)
	);
	assign out_test = fifo_out.test;
	assign out_a = fifo_out.lane_a;
	assign out_b = fifo_out.lane_b;

	// Checking helpers: previous pushed word and its validity
	logic [13:0] prev_word_ff;
	logic prev_ok_ff;
	always_ff @(posedge core_clk) begin
		if (reset | wr_ctrl) begin
			prev_word_ff <= 14'h0000;
			prev_ok_ff <= 1'b0;
		end else if (push) begin
			prev_word_ff <= sample.lane_a;
			prev_ok_ff <= 1'b1;
		end
	end

	// Checks run on the sample clock; reset masks them
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// Step sequences: a test sample taken, a generator sitting at its seed
	sequence s_push_pat(tpg_pat_type p);
		push & (pat == p) & test_on;
	endsequence
	sequence s_long_seeded;
		~long_hold & (pn_long_ff == `TPG_PN_LONG_SEED);
	endsequence
	sequence s_short_seeded;
		~short_hold & (pn_short_ff == `TPG_PN_SHORT_SEED);
	endsequence
	sequence s_pn_held(logic hold);
		hold & clk_en;
	endsequence

	AST_OFF_PASS: assert property (push & (code == `TPG_CODE_OFF) |-> ~sample.test & sample.lane_a == conv_a)
		else $error("Code zero did not pass data");
	AST_FIXED: assert property (s_push_pat(TPG_PAT_POS) |-> sample.lane_a == 14'h1FFF & sample.lane_b == 14'h1FFF)
		else $error("Positive full-scale word wrong");
	AST_RAMP: assert property (s_push_pat(TPG_PAT_RAMP) & prev_ok_ff |-> sample.lane_a == prev_word_ff + 14'h0001)
		else $error("Ramp did not step by one");
	AST_CHECK: assert property (s_push_pat(TPG_PAT_CHECK) & ~prev_ok_ff |-> sample.lane_a == 14'h1555)
		else $error("Checkerboard did not start with 0x1555");
	AST_ALT: assert property (s_push_pat(TPG_PAT_TOGGLE) & prev_ok_ff |-> sample.lane_a == (prev_word_ff ^ 14'h3FFF))
		else $error("Toggle did not alternate");
	AST_PN_LONG: assert property (s_long_seeded ##0 s_push_pat(TPG_PAT_PN_LONG) |-> sample.lane_a == 14'h3FD7)
		else $error("Long PN first word wrong");
	AST_PN_SHORT: assert property (s_short_seeded ##0 s_push_pat(TPG_PAT_PN_SHORT) |-> sample.lane_a == 14'h125B)
		else $error("Short PN first word wrong");
	AST_SINGLE: assert property (s_push_pat(TPG_PAT_USER) & udone_ff |-> sample.lane_a == 14'h0000)
		else $error("Single user mode did not output zeros");
	AST_USER: assert property (s_push_pat(TPG_PAT_USER) & ~udone_ff & uidx_ff == 2'h0
		|-> sample.lane_a == {user_ff[1], user_ff[0][7:2]})
		else $error("User pattern one word wrong");
	AST_HOLD: assert property (~push & ~wr_ctrl |=> $stable(ramp_ff) & $stable(phase_ff))
		else $error("Pattern advanced without a sample");
	AST_DDC: assert property (push & ddc_mode & ~ddc_test |-> sample.lane_a == conv_a & sample.lane_b == conv_b)
		else $error("Downconverter lanes carried test data while disabled");
	AST_RESERVED: assert property (push & (code inside {4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE}) |-> ~sample.test)
		else $error("Reserved code produced test data");

	// Fixed words and first or following words of the stepped patterns
	AST_MID: assert property (s_push_pat(TPG_PAT_MID)
		|-> sample.lane_a == 14'h0000 & sample.lane_b == 14'h0000)
		else $error("Midscale word wrong");
	AST_NEG: assert property (s_push_pat(TPG_PAT_NEG)
		|-> sample.lane_a == 14'h2000 & sample.lane_b == 14'h2000)
		else $error("Negative full-scale word wrong");
	AST_RAMP_START: assert property (s_push_pat(TPG_PAT_RAMP) & ~prev_ok_ff
		|-> sample.lane_a == 14'h0000)
		else $error("Ramp did not start at zero");
	AST_CHECK_ALT: assert property (s_push_pat(TPG_PAT_CHECK) & prev_ok_ff
		|-> sample.lane_a == (prev_word_ff ^ 14'h3FFF))
		else $error("Checkerboard did not alternate");
	AST_TOGGLE_START: assert property (s_push_pat(TPG_PAT_TOGGLE) & ~prev_ok_ff
		|-> sample.lane_a == 14'h0000)
		else $error("Toggle did not start with zeros");
	AST_USER_TWO: assert property (s_push_pat(TPG_PAT_USER) & ~udone_ff & uidx_ff == 2'h1
		|-> sample.lane_a == {user_ff[3], user_ff[2][7:2]})
		else $error("User pattern two word wrong");
	AST_USER_REPEAT: assert property (s_push_pat(TPG_PAT_USER) & ~single_mode
		|-> ~udone_ff)
		else $error("Repeat user mode stopped repeating");

	// Seed hold, clock enable freeze, read back and lane routing
	AST_LONG_HOLD: assert property (s_pn_held(long_hold)
		|=> pn_long_ff == `TPG_PN_LONG_SEED)
		else $error("Long PN not held at seed");
	AST_SHORT_HOLD: assert property (s_pn_held(short_hold)
		|=> pn_short_ff == `TPG_PN_SHORT_SEED)
		else $error("Short PN not held at seed");
	AST_FREEZE: assert property (~clk_en
		|=> $stable(ramp_ff) & $stable(pn_long_ff) & $stable(ctrl_ff) & $stable(out_valid))
		else $error("State moved while clock enable was low");
	AST_READ: assert property (clk_en & reg_rd & (reg_addr == `TPG_ADDR_CTRL)
		|=> reg_rdata == $past(ctrl_ff))
		else $error("Control register read back wrong");
	AST_PASS_B: assert property (push & ~test_on
		|-> sample.lane_b == conv_b & ~sample.test)
		else $error("Lane B did not pass converter data");
	AST_DDC_ON: assert property (push & ddc_mode & ddc_test & (pat != TPG_PAT_OFF)
		|-> sample.test & sample.lane_a == pat_word & sample.lane_b == pat_word)
		else $error("Enabled downconverter lanes missed test data");
endmodule

// *** design/tpg_regs.svh ***
// Register offsets, field positions, reset values and fixed pattern words
// of the converter test pattern generator. Definitions only.
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH

// Register offsets
`define TPG_ADDR_DDC_FIRST 12'h327
`define TPG_ADDR_DDC_SECOND 12'h347
`define TPG_ADDR_CTRL 12'h550
`define TPG_ADDR_USER_FIRST 12'h551
`define TPG_ADDR_USER_LAST 12'h558

// Reset values
`define TPG_RST_CTRL 8'h00
`define TPG_RST_DDC 8'h00
`define TPG_RST_USER 8'h00

// Control register fields
`define TPG_CTRL_CODE_MSB 3
`define TPG_CTRL_LONG_RST_BIT 4
`define TPG_CTRL_SHORT_RST_BIT 5
`define TPG_CTRL_SINGLE_BIT 7

// Downconverter test enable fields
`define TPG_DDC_EN_LO_BIT 0
`define TPG_DDC_EN_HI_BIT 2

// Test codes
`define TPG_CODE_OFF 4'h0
`define TPG_CODE_MID 4'h1
`define TPG_CODE_POS 4'h2
`define TPG_CODE_NEG 4'h3
`define TPG_CODE_CHECK 4'h4
`define TPG_CODE_PN_LONG 4'h5
`define TPG_CODE_PN_SHORT 4'h6
`define TPG_CODE_TOGGLE 4'h7
`define TPG_CODE_USER 4'h8
`define TPG_CODE_RAMP 4'hF

// Fixed words
`define TPG_WORD_ZERO 14'h0000
`define TPG_WORD_POS 14'h1FFF
`define TPG_WORD_NEG 14'h2000
`define TPG_WORD_CHK_A 14'h1555
`define TPG_WORD_CHK_B 14'h2AAA
`define TPG_WORD_ONES 14'h3FFF

// Pseudo-random generators: seed, length, second tap
`define TPG_PN_LONG_SEED 23'h003AFF
`define TPG_PN_LONG_LEN 23
`define TPG_PN_LONG_TAP 5
`define TPG_PN_SHORT_SEED 23'h000092
`define TPG_PN_SHORT_LEN 9
`define TPG_PN_SHORT_TAP 4
`define TPG_PN_LONG_FIRST 14'h3FD7
`define TPG_PN_SHORT_FIRST 14'h125B

`endif

// *** design/tpg_pkg.sv ***
// Types of the test pattern generator; its output buffer only takes their width as W.
// Assumes tpg_regs.svh carries the numeric constants.
package tpg_pkg;

	// One output sample: test flag plus the two lanes (A or I, B or Q)
	typedef struct packed {
		logic test;
		logic [13:0] lane_a;
		logic [13:0] lane_b;
	} tpg_sample_type;

	// Decoded pattern selection
	typedef enum logic [3:0] {
		TPG_PAT_OFF,
		TPG_PAT_MID,
		TPG_PAT_POS,
		TPG_PAT_NEG,
		TPG_PAT_CHECK,
		TPG_PAT_PN_LONG,
		TPG_PAT_PN_SHORT,
		TPG_PAT_TOGGLE,
		TPG_PAT_USER,
		TPG_PAT_RAMP
	} tpg_pat_type;

endpackage

// *** design/tpg_fifo.sv ***
// Sample buffer between the pattern generator and the formatting stage.
// Assumes one clock; clk_en low freezes every flop.
`timescale 1ns/1ps
module tpg_fifo #(
	parameter int W = 29,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [CW-1:0] count_ff;
	logic ready_ff;
	logic valid_ff;
	logic [W-1:0] data_ff;
	wire push = clk_en & in_valid & ready_ff;
	wire pop = clk_en & (~valid_ff | out_ready) & (count_ff != '0);
	wire drain = clk_en & valid_ff & out_ready;
	wire [CW-1:0] nxt_count = count_ff + CW'(push) - CW'(pop);

	assign in_ready = ready_ff;
	assign out_valid = valid_ff;
	assign out_data = data_ff;

	// Storage and pointers
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
		if (reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			ready_ff <= 1'b0;
		end else if (clk_en) begin
			wr_ptr_ff <= push ? AW'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
			rd_ptr_ff <= pop ? AW'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
			count_ff <= nxt_count;
			ready_ff <= nxt_count != CW'(DEPTH); // Full stalls the source
		end
	end

	// Registered output stage
	always_ff @(posedge core_clk) begin
		if (reset) begin
			valid_ff <= 1'b0;
			data_ff <= '0;
		end else if (pop) begin
			valid_ff <= 1'b1;
			data_ff <= mem_ff[rd_ptr_ff];
		end else if (drain) begin
			valid_ff <= 1'b0;
		end
	end
endmodule

// *** sim/tpg_sink.sv ***
// Model of the output formatting stage that takes generator words.
// Assumes core_clk domain; mode 0 ready, 1 stalled, 2 ready every other cycle.
`timescale 1ns/1ps
module tpg_sink (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [1:0] mode,
	input wire logic out_valid,
	input wire logic out_test,
	input wire logic [13:0] out_a,
	input wire logic [13:0] out_b,
	output logic out_ready
);
	logic [28:0] got[$];
	logic phase_ff;
	// Ready per mode, slow mode alternates
	assign out_ready = (mode == 2'h0) || (mode == 2'h2 && phase_ff);
	// Record each accepted word, frozen with the design
	always @(posedge core_clk) begin
		phase_ff <= reset ? 1'b0 : ~phase_ff;
		if (!reset && clk_en && out_valid && out_ready) begin
			got.push_back({out_test, out_a, out_b});
		end
	end
endmodule

// *** sim/adc_output_test_pattern_gen_tb.sv ***
// Self-checking bench for the converter test pattern generator.
// Assumes tpg_pkg, tpg_gen and tpg_sink are compiled before it.
`timescale 1ns/1ps
module adc_output_test_pattern_gen_tb;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ddc_mode = 1'b0;
	logic conv_valid = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic [13:0] conv_a = 14'h0000;
	logic [13:0] conv_b = 14'h0000;
	logic [1:0] mode = 2'h0;
	logic [7:0] reg_rdata;
	logic conv_ready, out_valid, out_ready, out_test;
	logic [13:0] out_a, out_b;
	int n_errors = 0;
	int total_checks = 0;
	logic [15:0] up [4] = '{16'hA5C3, 16'h5A3C, 16'hFFFF, 16'h0001};
	logic [13:0] pl [5] = '{14'h3FD7, 14'h0002, 14'h26E0, 14'h0A3D, 14'h1CA6};
	logic [13:0] ps [5] = '{14'h125B, 14'h3C9A, 14'h2660, 14'h0C65, 14'h0697};

	// Clock, 4 ns period
	always #2 core_clk = ~core_clk;

	tpg_gen dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ddc_mode(ddc_mode),
		.conv_valid(conv_valid), .conv_a(conv_a), .conv_b(conv_b), .conv_ready(conv_ready),
		.out_valid(out_valid), .out_ready(out_ready), .out_test(out_test), .out_a(out_a), .out_b(out_b));
	tpg_sink sink (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .mode(mode), .out_valid(out_valid),
		.out_test(out_test), .out_a(out_a), .out_b(out_b), .out_ready(out_ready));

	// Bus and stream helpers
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	task automatic check(string what, logic [28:0] exp, logic [28:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask
	task automatic rd(logic [11:0] a, logic [7:0] exp);
		reg_rd = 1'b1;
		reg_addr = a;
		tick();
		reg_rd = 1'b0;
		check("reg_rdata", 29'(exp), 29'(reg_rdata));
		tick();
	endtask
	// Expected word for sample i under a control value
	function automatic logic [28:0] expw(logic [7:0] ctrl, int i, logic pass);
		logic [13:0] w;
		w = 14'h0000;
		case (ctrl[3:0])
			4'h1: w = 14'h0000;
			4'h2: w = 14'h1FFF;
			4'h3: w = 14'h2000;
			4'h4: w = i[0] ? 14'h2AAA : 14'h1555;
			4'h5: w = pl[i];
			4'h6: w = ps[i];
			4'h7: w = i[0] ? 14'h3FFF : 14'h0000;
			4'h8: w = (ctrl[7] && i > 3) ? 14'h0000 : up[i % 4][15:2];
			4'hF: w = 14'(i);
			default: pass = 1'b1;
		endcase
		if (pass) begin
			return {1'b0, 14'(i * 37 + 5), 14'(9000 - i * 11)};
		end
		return {1'b1, w, w};
	endfunction
	task automatic setc(logic [7:0] ctrl);
		wr(12'h550, ctrl | 8'h30);
		wr(12'h550, ctrl);
		sink.got.delete();
	endtask
	task automatic send(int n, int base, logic fz);
		int k;
		for (int i = 0; i < n; i++) begin
			conv_valid = 1'b1;
			conv_a = 14'((base + i) * 37 + 5);
			conv_b = 14'(9000 - (base + i) * 11);
			if (fz && i == 2) begin
				clk_en = 1'b0;
				repeat (4) tick();
				clk_en = 1'b1;
			end
			k = 0;
			while (conv_ready !== 1'b1 && k < 50) begin
				tick();
				k++;
			end
			tick();
		end
		conv_valid = 1'b0;
	endtask
	task automatic drain(string name, logic [7:0] ctrl, int n, logic pass);
		int k;
		k = 0;
		while (sink.got.size() < n && k < 100) begin
			tick();
			k++;
		end
		check("word count", 29'(n), 29'(sink.got.size()));
		for (int i = 0; i < n && i < sink.got.size(); i++) begin
			check(name, expw(ctrl, i, pass | (ctrl[3:0] == 4'h0)), sink.got[i]);
		end
		tick();
		check("out_valid idle", 29'h0, 29'(out_valid));
		$display("test %s done", name);
	endtask
	task automatic run(string name, logic [7:0] ctrl, int n, logic pass, logic fz);
		setc(ctrl);
		send(n, 0, fz);
		drain(name, ctrl, n, pass);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		int k;
		repeat (20) tick();
		reset = 1'b0;
		tick();
		rd(12'h550, 8'h00);
		rd(12'h327, 8'h00);
		rd(12'h347, 8'h00);
		wr(12'h123, 8'h5A);
		rd(12'h123, 8'h00);
		for (int j = 0; j < 4; j++) begin
			wr(12'(12'h551 + 2 * j), up[j][7:0]);
			wr(12'(12'h552 + 2 * j), up[j][15:8]);
		end
		rd(12'h558, up[3][15:8]);
		run("pass", 8'h00, 6, 1'b0, 1'b1);
		run("mid", 8'h01, 3, 1'b0, 1'b0);
		run("pos", 8'h02, 3, 1'b0, 1'b0);
		run("neg", 8'h03, 3, 1'b0, 1'b0);
		run("check", 8'h04, 6, 1'b0, 1'b1);
		run("pn long", 8'h05, 5, 1'b0, 1'b0);
		run("pn long again", 8'h05, 5, 1'b0, 1'b0);
		run("pn short", 8'h06, 5, 1'b0, 1'b0);
		run("pn short again", 8'h06, 5, 1'b0, 1'b0);
		run("toggle", 8'h07, 5, 1'b0, 1'b0);
		run("user repeat", 8'h08, 9, 1'b0, 1'b0);
		run("user single", 8'h88, 7, 1'b0, 1'b0);
		for (int c = 9; c < 15; c++) begin
			run("reserved", 8'(c), 3, 1'b0, 1'b0);
		end
		ddc_mode = 1'b1;
		run("ddc off", 8'h04, 3, 1'b1, 1'b0);
		wr(12'h327, 8'h01);
		run("ddc half", 8'h04, 3, 1'b1, 1'b0);
		wr(12'h327, 8'h05);
		run("ddc first", 8'h04, 4, 1'b0, 1'b0);
		wr(12'h327, 8'h00);
		wr(12'h347, 8'h05);
		run("ddc second", 8'h07, 4, 1'b0, 1'b0);
		ddc_mode = 1'b0;
		mode = 2'h2;
		run("slow sink", 8'h04, 6, 1'b0, 1'b0);
		mode = 2'h1;
		setc(8'h04);
		conv_valid = 1'b1;
		k = 0;
		while (conv_ready === 1'b1 && k < 20) begin
			tick();
			k++;
		end
		check("refused", 29'h0, 29'(conv_ready));
		check("stored", 29'h9, 29'(k));
		repeat (5) tick();
		mode = 2'h0;
		send(4, k, 1'b0);
		drain("full buffer", 8'h04, k + 4, 1'b0);
		run("ramp", 8'h0F, 16390, 1'b0, 1'b0);
		end_of_test();
	end

	// Watchdog on a hung handshake
	initial begin
		#(40000 * 4);
		n_errors++;
		$display("mismatch watchdog expected done seen timeout");
		end_of_test();
	end
endmodule
